// >>> bench/asc_host_model.sv
// Serial port master that frames control writes and result reads.
`timescale 1ns/1ns
module asc_host_model (
    // Clock of the driving logic.
    input  wire logic i_clk_sys,
    // Serial pins.
    input  wire logic i_serial_out,
    input  wire logic i_serial_out_en,
    output logic      o_shift_clk,
    output logic      o_write_frame_sync,
    output logic      o_read_frame_sync,
    output logic      o_serial_in
);
    // A released line floats; showing the inverse of the last bit keeps a stale value from passing.
    wire line_seen = i_serial_out_en ? i_serial_out : ~i_serial_out;
    // The shift clock idles high and stands still between frames.
    initial begin
        o_shift_clk        = 1'b1;
        o_write_frame_sync = 1'b1;
        o_read_frame_sync  = 1'b0;
        o_serial_in        = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk_sys);
    endtask
    // Half of the 800 ns shift clock is four system cycles.
    task automatic write_word(input logic [9:0] w, input logic [2:0] tail);
        logic [12:0] f;
        f = {w, tail};
        o_write_frame_sync <= 1'b0;
        tick(4);
        for (int i = 12; i >= 0; i--) begin
            o_serial_in <= f[i];
            tick(4);
            o_shift_clk <= 1'b0;
            tick(4);
            o_shift_clk <= 1'b1;
        end
        o_write_frame_sync <= 1'b1;
        o_serial_in        <= ~f[0];
        tick(8);
    endtask
    // Data is taken late in each period, since the output lags the edge by the sync stages.
    task automatic read_word(output logic [9:0] d, output logic [10:0] en);
        o_read_frame_sync <= 1'b1;
        tick(4);
        for (int i = 10; i >= 0; i--) begin
            o_shift_clk <= 1'b0;
            tick(4);
            o_shift_clk <= 1'b1;
            tick(7);
            en[i] = i_serial_out_en;
            if (i > 0) d[i-1] = line_seen;
            tick(1);
        end
        o_read_frame_sync <= 1'b0;
        tick(8);
    endtask
endmodule

// >>> bench/tb_asc_serial_ctrl.sv
// Self-checking bench of the serial conversion controller.
`timescale 1ns/1ns
module tb_asc_serial_ctrl;
    import asc_pkg::*;
    logic        clk, arst_n, psel, penable, pwrite, pready, pslverr, se;
    logic        sclk, wfs, read_frame_sync, sdi, sdo, sdo_en, trig, pkg, hold, pfull, ppart, xref;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [9:0]  res, cfg, dat, last;
    logic [3:0]  chan;
    logic [10:0] en;
    logic [9:0]  exp_q[$];
    int          n_fail, checks_done, cyc, hl_cnt, hl_last, stray;

    asc_serial_ctrl i_asc_serial_ctrl (.i_clk_sys(clk), .i_arst_n(arst_n), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_shift_clk(sclk),
        .i_write_frame_sync(wfs), .i_read_frame_sync(read_frame_sync), .i_serial_in(sdi),
        .o_serial_out(sdo), .o_serial_out_en(sdo_en), .i_conversion_trigger(trig),
        .i_package_select(pkg), .i_conv_result(res), .o_hold(hold), .o_power_full(pfull),
        .o_power_partial(ppart), .o_external_ref_select(xref), .o_channel_cfg(chan));
    asc_host_model i_asc_host_model (.i_clk_sys(clk), .i_serial_out(sdo), .i_serial_out_en(sdo_en),
        .o_shift_clk(sclk), .o_write_frame_sync(wfs), .o_read_frame_sync(read_frame_sync), .o_serial_in(sdi));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // Hold length is measured here so that a start inside a frame is still seen whole.
    always @(posedge clk) begin
        cyc++;
        if (hold === 1'b1) hl_cnt++;
        else if (hl_cnt > 0) begin
            hl_last = hl_cnt;
            hl_cnt  = 0;
        end
        if (sdo_en === 1'b1 && read_frame_sync === 1'b0) stray++;
        if (cyc == 20000) begin
            n_fail++;
            give_verdict();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        rd = prdata;
        se = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic conv(input logic lvl, input logic sw);
        res     <= 10'($urandom);
        trig    <= 1'b1;
        hl_last = 0;
        repeat (4) @(posedge clk);
        if (sw) i_asc_host_model.write_word(cfg | CW_SWCONV_MASK, 3'($urandom));
        else trig <= 1'b0;
        repeat (8) @(posedge clk);
        trig <= lvl;
        for (int t = 0; t < 60 && hl_last == 0; t++) @(posedge clk);
        chk(32'(hl_last), 32'(CONV_CYC));
        repeat (2) @(posedge clk);
        exp_q.push_back(res);
    endtask

    task automatic rd_chk;
        i_asc_host_model.read_word(dat, en);
        if (exp_q.size() > 0) last = exp_q.pop_front();
        chk({22'h0, dat}, {22'h0, last});
        chk({21'h0, en}, {21'h0, 11'h7FE});
    endtask

    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {trig, pkg, res, arst_n, last} = {1'b1, 1'b1, 10'h0, 1'b0, 10'h0};
        void'($urandom(32'h88F3D3C3));
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge clk);
        chk({28'h0, pfull, ppart, hold, sdo_en}, 32'h8);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(rd, 32'h0000_1000);
        apb(1'b1, ADDR_STATUS, 32'h3FF);
        apb(1'b0, ADDR_CONFIG, 32'h0);
        chk(rd, 32'(CONFIG_RESET));
        apb(1'b0, 8'h08, 32'h0);
        chk({se, rd[30:0]}, 32'h8000_0000);
        // Every power select code; the pin level follows the address bit to share the bus.
        for (int pd = 0; pd < 4; pd++) begin
            pkg <= pd[0];
            cfg = {1'b0, pd[0], 2'(pd), 4'($urandom), 2'b01};
            i_asc_host_model.write_word(cfg, 3'($urandom));
            apb(1'b0, ADDR_STATUS, 32'h0);
            chk({21'h0, rd[10:0]}, {21'h0, 1'b1, cfg});
            chk({27'h0, xref, chan}, {27'h0, cfg[0], cfg[5:2]});
            if (pd != 0) conv(1'b0, 1'b0);
            chk({30'h0, pfull, ppart}, {30'h0, pd == 0 || pd == 2, pd == 1});
        end
        // Three results against two entries; the fourth read finds the buffer empty.
        repeat (4) rd_chk();
        i_asc_host_model.write_word({cfg[9], 1'b0, cfg[7:0]}, 3'h7);
        i_asc_host_model.read_word(dat, en);
        chk({21'h0, en}, 32'h0);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk({21'h0, rd[10:0]}, {22'h0, cfg});
        conv(1'b1, 1'b1);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk({21'h0, rd[10:0]}, {21'h0, 1'b1, cfg});
        rd_chk();
        apb(1'b1, ADDR_CONFIG, 32'h0);
        i_asc_host_model.read_word(dat, en);
        chk({21'h0, en}, 32'h0);
        apb(1'b1, ADDR_CONFIG, 32'h1);
        rd_chk();
        chk(32'(stray), 32'h0);
        give_verdict();
    end
endmodule

// >>> hdl/asc_result_buf.sv
// Two-entry result buffer with valid and ready on both sides.
`timescale 1ns/1ns
module asc_result_buf
    import asc_pkg::*;
(
    // Clock and reset.
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    // Buffer handshake.
    asc_buf_if.buffer bus
);
    logic [WORD_BITS-1:0] mem_reg [BUF_DEPTH];
    logic                 wr_ptr_reg;
    logic                 rd_ptr_reg;
    logic [1:0]           count_reg;

    wire push = bus.in_valid & bus.in_ready;
    wire pop  = bus.out_valid & bus.out_ready;

    assign bus.in_ready  = count_reg != 2'(BUF_DEPTH);
    assign bus.out_valid = count_reg != 2'h0;
    assign bus.out_data  = mem_reg[rd_ptr_reg];

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg  <= 2'h0;
            mem_reg[0] <= 10'h000;
            mem_reg[1] <= 10'h000;
        end else begin
            if (push) begin
                mem_reg[wr_ptr_reg] <= bus.in_data;
                wr_ptr_reg          <= ~wr_ptr_reg;
            end
            if (pop) begin
                rd_ptr_reg <= ~rd_ptr_reg;
            end
            count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
        end
    end

    a_buf_bounds : assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        count_reg <= 2'(BUF_DEPTH)) else $error("Result buffer count out of range.");
endmodule

// >>> hdl/asc_serial_ctrl.sv
// Serial control, conversion start and result read-out of a 10-bit sampling converter.
//
// Functional notes
// - After write sync falls, capture ten control bits on shift clock falling edges.
// - Host gives thirteen clocks per write; only the first ten bits are kept.
// - Output changes on rising shift clock edges; input sampled on falling edges.
// - Serial output released on the eleventh rising shift clock edge of a read.
// - Shift clock ignored for reading until read sync rises.
// - Read sync rise enables the bit counter; it resets when the read ends.
// - Trigger falling edge puts track/hold into hold and starts a conversion.
// - Trigger level at end of conversion decides power-down.
// - Package select pin and address bit let two devices share a bus.
// - Word with mismatching address dropped; only last addressed device drives reads.
// - Software convert bit starts conversion 400 ns later, cleared at end.
// - Power-down select: 00 off now, 01 partial, 10 full, 11 up.
// - Control word resets to zero, so the device starts powered down.
//
// The register offsets and register access over APB were decided locally.
`timescale 1ns/1ns
module asc_serial_ctrl
    import asc_pkg::*;
(
    // Clock and reset.
    input  wire logic        i_clk_sys,
    input  wire logic        i_arst_n,
    // APB slave.
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // Serial link pins.
    input  wire logic        i_shift_clk,
    input  wire logic        i_write_frame_sync,
    input  wire logic        i_read_frame_sync,
    input  wire logic        i_serial_in,
    output logic             o_serial_out,
    output logic             o_serial_out_en,
    // Converter pins and core.
    input  wire logic        i_conversion_trigger,
    input  wire logic        i_package_select,
    input  wire logic [9:0]  i_conv_result,
    output logic             o_hold,
    output logic             o_power_full,
    output logic             o_power_partial,
    output logic             o_external_ref_select,
    output logic      [3:0]  o_channel_cfg
);
    function automatic logic rise_edge(input logic cur, input logic prev);
        return cur & ~prev;
    endfunction

    function automatic logic fall_edge(input logic cur, input logic prev);
        return prev & ~cur;
    endfunction

    // Pin synchronisers; only sync2 and prev are read by logic.
    logic [5:0] sync1_reg;
    logic [5:0] sync2_reg;
    logic [5:0] prev_reg;

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sync1_reg <= 6'h00;
            sync2_reg <= 6'h00;
            prev_reg  <= 6'h00;
        end else begin
            sync1_reg <= {i_package_select, i_conversion_trigger, i_serial_in,
                          i_read_frame_sync, i_write_frame_sync, i_shift_clk};
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
        end
    end

    wire s_din     = sync2_reg[PIN_DIN];
    wire s_trig    = sync2_reg[PIN_TRIG];
    wire s_pkg     = sync2_reg[PIN_PKG];
    wire sclk_rise = rise_edge(sync2_reg[PIN_SCLK], prev_reg[PIN_SCLK]);
    wire sclk_fall = fall_edge(sync2_reg[PIN_SCLK], prev_reg[PIN_SCLK]);
    wire wfs_fall  = fall_edge(sync2_reg[PIN_WFS], prev_reg[PIN_WFS]);
    wire rfs_rise  = rise_edge(sync2_reg[PIN_RFS], prev_reg[PIN_RFS]);
    wire trig_fall = fall_edge(s_trig, prev_reg[PIN_TRIG]);
    wire trig_rise = rise_edge(s_trig, prev_reg[PIN_TRIG]);

    // Registers seen by software and state shared by the paths.
    logic          cfg_enable_reg;
    logic [9:0]    ctrl_reg;
    logic          sel_reg;
    asc_conv_type  cv_reg;
    asc_conv_type  cv_next;
    logic [4:0]    cv_cnt_reg;
    logic [4:0]    cv_cnt_next;
    asc_power_type pw_reg;
    asc_power_type pw_next;

    // Control word write path.
    logic       wr_armed_reg;
    logic [3:0] wr_cnt_reg;
    logic [9:0] wr_shift_reg;

    wire       wr_start   = wfs_fall & cfg_enable_reg;
    wire       wr_bit     = wr_armed_reg & sclk_fall;
    wire [3:0] wr_cnt_inc = wr_cnt_reg + 4'h1;
    wire       word_done  = wr_bit & (wr_cnt_inc == WR_BITS);
    wire [9:0] wr_word    = {wr_shift_reg[8:0], s_din};
    wire       addr_match = wr_word[CW_ADDR_BIT] == s_pkg;
    wire       word_load  = word_done & addr_match;

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wr_armed_reg <= 1'b0;
            wr_cnt_reg   <= 4'h0;
            wr_shift_reg <= 10'h000;
            sel_reg      <= 1'b0;
        end else if (wr_start) begin
            wr_armed_reg <= 1'b1;
            wr_cnt_reg   <= 4'h0;
        end else if (wr_bit) begin
            wr_shift_reg <= wr_word;
            wr_cnt_reg   <= wr_cnt_inc;
            if (word_done) begin
                wr_armed_reg <= 1'b0;
                sel_reg      <= addr_match;
            end
        end
    end

    // Control word; a new word wins over the end-of-conversion clear.
    wire       conv_end  = (cv_reg == CV_BUSY) && (cv_cnt_reg == 5'h00);
    wire [9:0] ctrl_next = word_load ? wr_word
                         : conv_end  ? (ctrl_reg & ~CW_SWCONV_MASK)
                         : ctrl_reg;
    wire [1:0] pd_sel    = ctrl_reg[CW_PD_HI:CW_PD_LO];
    wire [1:0] wr_pd     = wr_word[CW_PD_HI:CW_PD_LO];

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ctrl_reg <= CTRL_RESET;
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    // Conversion sequencing.
    asc_buf_if rbuf ();
    wire hw_start = trig_fall && (pd_sel != PD_FULL_NOW);
    wire sw_start = word_load && wr_word[CW_SWCONV_BIT] && (wr_pd != PD_FULL_NOW);

    always_comb begin
        cv_next     = cv_reg;
        cv_cnt_next = cv_cnt_reg;
        case (cv_reg)
            CV_IDLE: begin
                if (sw_start) begin
                    cv_next     = CV_WAIT;
                    cv_cnt_next = SW_START_LOAD;
                end else if (hw_start) begin
                    cv_next     = CV_BUSY;
                    cv_cnt_next = CONV_LOAD;
                end
            end
            CV_WAIT: begin
                if (cv_cnt_reg == 5'h00) begin
                    cv_next     = CV_BUSY;
                    cv_cnt_next = CONV_LOAD;
                end else begin
                    cv_cnt_next = cv_cnt_reg - 5'h01;
                end
            end
            CV_BUSY: begin
                if (conv_end) begin
                    cv_next = CV_PUSH;
                end else begin
                    cv_cnt_next = cv_cnt_reg - 5'h01;
                end
            end
            CV_PUSH: begin
                if (rbuf.in_ready) begin
                    cv_next = CV_IDLE;
                end
            end
            default: begin
                cv_next     = CV_IDLE;
                cv_cnt_next = 5'h00;
            end
        endcase
    end

    // Power decision; codes 00 and 11 override the end-of-conversion choice.
    always_comb begin
        case (pd_sel)
            PD_FULL_NOW: pw_next = PW_FULL;
            PD_POWER_UP: pw_next = PW_UP;
            default: begin
                if (conv_end) begin
                    pw_next = s_trig ? PW_UP
                            : (pd_sel == PD_PARTIAL_EOC) ? PW_PARTIAL : PW_FULL;
                end else if (trig_rise || cv_reg == CV_WAIT || cv_reg == CV_BUSY) begin
                    pw_next = PW_UP;
                end else begin
                    pw_next = pw_reg;
                end
            end
        endcase
    end

    logic [9:0] held_result_reg;

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cv_reg          <= CV_IDLE;
            cv_cnt_reg      <= 5'h00;
            pw_reg          <= PW_FULL;
            held_result_reg <= 10'h000;
            o_hold          <= 1'b0;
        end else begin
            cv_reg     <= cv_next;
            cv_cnt_reg <= cv_cnt_next;
            pw_reg     <= pw_next;
            o_hold     <= cv_next == CV_BUSY;
            if (conv_end) begin
                held_result_reg <= i_conv_result;
            end
        end
    end

    // A full buffer keeps the converter in the push state, so no result is lost.
    assign rbuf.in_valid = cv_reg == CV_PUSH;
    assign rbuf.in_data  = held_result_reg;

    asc_result_buf u_buf (
        .i_clk_sys (i_clk_sys),
        .i_arst_n  (i_arst_n),
        .bus       (rbuf.buffer)
    );

    // Result read path.
    logic       rd_active_reg;
    logic [3:0] rd_cnt_reg;
    logic [9:0] rd_shift_reg;
    logic [9:0] last_result_reg;

    wire rd_start = rfs_rise & cfg_enable_reg & sel_reg & ~rd_active_reg;
    wire rd_edge  = rd_active_reg & sclk_rise;
    wire rd_last  = rd_cnt_reg == RD_BITS;
    assign rbuf.out_ready = rd_start;

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rd_active_reg   <= 1'b0;
            rd_cnt_reg      <= 4'h0;
            rd_shift_reg    <= 10'h000;
            last_result_reg <= 10'h000;
            o_serial_out    <= 1'b0;
            o_serial_out_en <= 1'b0;
        end else if (rd_start) begin
            rd_active_reg <= 1'b1;
            rd_cnt_reg    <= 4'h0;
            if (rbuf.out_valid) begin
                rd_shift_reg    <= rbuf.out_data;
                last_result_reg <= rbuf.out_data;
            end else begin
                rd_shift_reg <= last_result_reg;
            end
        end else if (rd_edge) begin
            if (rd_last) begin
                o_serial_out_en <= 1'b0;
                rd_active_reg   <= 1'b0;
                rd_cnt_reg      <= 4'h0;
            end else begin
                o_serial_out    <= rd_shift_reg[9];
                o_serial_out_en <= 1'b1;
                rd_shift_reg    <= {rd_shift_reg[8:0], 1'b0};
                rd_cnt_reg      <= rd_cnt_reg + 4'h1;
            end
        end
    end

    // APB slave; one wait state so that read data come from a flip-flop.
    wire        apb_acc    = i_psel & i_penable;
    wire        apb_commit = apb_acc & o_pready;
    wire        hit_status = i_paddr == ADDR_STATUS;
    wire        hit_config = i_paddr == ADDR_CONFIG;
    wire [31:0] status_word = {16'h0000, rd_active_reg, pw_reg, cv_reg != CV_IDLE, sel_reg, ctrl_reg};
    wire [31:0] read_mux   = hit_status ? status_word
                           : hit_config ? {31'h00000000, cfg_enable_reg}
                           : 32'h00000000;

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_pready       <= 1'b0;
            o_prdata       <= 32'h00000000;
            o_pslverr      <= 1'b0;
            cfg_enable_reg <= CONFIG_RESET;
        end else begin
            o_pready <= apb_acc & ~o_pready;
            if (apb_acc & ~o_pready) begin
                o_prdata  <= read_mux;
                o_pslverr <= ~(hit_status | hit_config);
            end
            if (apb_commit & i_pwrite & hit_config) begin
                cfg_enable_reg <= i_pwdata[0];
            end
        end
    end

    // The host sets this bit for an external or supply reference.
    assign o_external_ref_select = ctrl_reg[CW_EXTERNAL_REF_SELECT_BIT];
    assign o_channel_cfg         = ctrl_reg[CW_CH_HI:CW_CH_LO];
    assign o_power_full          = pw_reg[0];
    assign o_power_partial       = pw_reg[1];

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_arst_n);

    sequence s_sw_wait;
        (cv_reg == CV_WAIT) [*4];
    endsequence

    a_write_bit_count : assert property (wr_cnt_reg <= WR_BITS)
        else $error("Write bit counter passed ten.");
    a_word_only_loads : assert property ($changed(ctrl_reg) |-> $past(word_load) || $past(conv_end))
        else $error("Control word changed outside a load or clear.");
    a_out_on_rise : assert property ($changed(o_serial_out) |-> $past(sclk_rise))
        else $error("Serial output changed without a rising shift edge.");
    a_release_eleventh : assert property (rd_edge && rd_last |=> !o_serial_out_en)
        else $error("Output not released on eleventh rising edge.");
    a_idle_no_drive : assert property (!rd_active_reg |-> !o_serial_out_en)
        else $error("Serial output driven outside a read.");
    a_counter_cleared : assert property ($fell(rd_active_reg) |-> rd_cnt_reg == 4'h0)
        else $error("Read counter not reset at end of read.");
    a_trigger_holds : assert property (cv_reg == CV_IDLE && hw_start && !sw_start |=> o_hold [*3])
        else $error("Trigger edge did not enter hold.");
    a_eoc_power : assert property (conv_end && s_trig && pd_sel != PD_FULL_NOW |=> pw_reg == PW_UP)
        else $error("High trigger at end of conversion still powered down.");
    a_addr_mismatch : assert property (word_done && !addr_match |=> !sel_reg)
        else $error("Mismatched word left the device selected.");
    a_sw_delay : assert property ($rose(cv_reg == CV_WAIT) |-> s_sw_wait ##1 cv_reg == CV_BUSY)
        else $error("Software start delay is not four cycles.");
    a_full_now : assert property (pd_sel == PD_FULL_NOW |=> pw_reg == PW_FULL)
        else $error("Code 00 did not power down at once.");
    a_read_bit_drive : assert property (rd_edge && !rd_last |=> o_serial_out_en)
        else $error("Result bit not driven on a rising edge.");
endmodule

// >>> inc/asc_buf_if.sv
// Handshake carrier between the controller and its result buffer.
`timescale 1ns/1ns
interface asc_buf_if;
    import asc_pkg::*;
    logic                 in_valid;
    logic                 in_ready;
    logic [WORD_BITS-1:0] in_data;
    logic                 out_valid;
    logic                 out_ready;
    logic [WORD_BITS-1:0] out_data;
    modport buffer (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
    modport user   (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface

// >>> inc/asc_pkg.sv
// Shared constants and types of the serial conversion controller.
package asc_pkg;
    localparam int CLK_PERIOD_NS = 100;
    localparam int SW_START_NS   = 400;
    localparam int SW_START_CYC  = (SW_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CONV_TIME_NS  = 2300;
    localparam int CONV_CYC      = CONV_TIME_NS / CLK_PERIOD_NS;
    localparam int WORD_BITS     = 10;
    localparam int BUF_DEPTH     = 2;

    localparam logic [3:0] WR_BITS = 4'hA;
    localparam logic [3:0] RD_BITS = 4'hA;
    localparam logic [4:0] SW_START_LOAD = 5'(SW_START_CYC - 1);
    localparam logic [4:0] CONV_LOAD     = 5'(CONV_CYC - 1);

    localparam int CW_ADDR_BIT   = 8;
    localparam int CW_PD_HI      = 7;
    localparam int CW_PD_LO      = 6;
    localparam int CW_CH_HI      = 5;
    localparam int CW_CH_LO      = 2;
    localparam int CW_SWCONV_BIT = 1;
    localparam int CW_EXTERNAL_REF_SELECT_BIT = 0;
    localparam logic [9:0] CW_SWCONV_MASK = 10'h002;
    localparam logic [9:0] CTRL_RESET     = 10'h000;

    localparam logic [1:0] PD_FULL_NOW    = 2'h0;
    localparam logic [1:0] PD_PARTIAL_EOC = 2'h1;
    localparam logic [1:0] PD_FULL_EOC    = 2'h2;
    localparam logic [1:0] PD_POWER_UP    = 2'h3;

    localparam logic [7:0] ADDR_STATUS  = 8'h00;
    localparam logic [7:0] ADDR_CONFIG  = 8'h04;
    localparam logic       CONFIG_RESET = 1'h1;

    localparam int PIN_SCLK = 0;
    localparam int PIN_WFS  = 1;
    localparam int PIN_RFS  = 2;
    localparam int PIN_DIN  = 3;
    localparam int PIN_TRIG = 4;
    localparam int PIN_PKG  = 5;

    typedef enum logic [3:0] {
        CV_IDLE = 4'b0001,
        CV_WAIT = 4'b0010,
        CV_BUSY = 4'b0100,
        CV_PUSH = 4'b1000
    } asc_conv_type;

    typedef enum logic [2:0] {
        PW_FULL    = 3'b001,
        PW_PARTIAL = 3'b010,
        PW_UP      = 3'b100
    } asc_power_type;
endpackage
